// ===== ebbs_top.sv
`timescale 1ns/1ps
// Function
// - Per-block full or half data width
// - Half-width access floats upper data pins
// - Word address output spans 64-Mbyte block
// - Full width: byte lanes by four strobes
// - Half width: two strobes, A30, fourth high
// - Strobe n qualifies data byte lane n
// - Direction high read, low write; SDRAM untouched
// - Hold request granted by acknowledge output
// - One block select low; none for SDRAM
// - Idle: data floats, address kept, controls high
// - Select delay zero to three clocks
// - Start phase exactly one clock
// - Read and write waits zero to 31
// - Ready inactive adds waits until active
// - Ready active level is configurable
// - End phase exactly one clock
// - Read recovery zero to three clocks
// - Write recovery zero to three clocks
// - Next-access gap zero to fifteen clocks
// - Page waits and strobe delay configurable
// - Page timing for fills and DMA bursts
// - Block 1 goes to user IP bus
module ebbs_top
  import ebbs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [2:0]  req_block,
  input  wire logic [25:0] req_addr,
  input  wire logic        req_write,
  input  wire logic [3:0]  req_be,
  input  wire logic [31:0] req_wdata,
  input  wire logic        req_page,
  input  wire logic        req_sdram,
  output logic             resp_valid,
  output logic      [31:0] resp_rdata,
  input  wire logic [31:0] ip_rdata,
  output logic             user_ip_bus_select,
  output logic      [23:0] ext_addr,
  input  wire logic [31:0] data_in,
  output logic      [31:0] data_out,
  output logic      [1:0]  data_oe,
  output logic             read_strobe_n,
  output logic      [3:0]  byte_write_strobe_n,
  output logic             read_write_n,
  output logic      [7:0]  block_select_n,
  input  wire logic        hold_req_n,
  output logic             bus_grant_out_n,
  input  wire logic        ready_in
);
  ebbs_state_t state;
  ebbs_state_t next_state;
  logic [4:0]  cnt;
  logic [4:0]  next_cnt;
  logic [31:0] sel_cr0, sel_cr1, sel_cr2;
  logic [31:0] status;
  logic [31:0] data_sync;
  logic        hold_sync_n, ready_sync;
  logic        take;

  // Latched attributes of the access in flight
  logic [2:0]  cur_blk;
  logic        cur_write, cur_half, cur_sdram, cur_ip;
  logic [3:0]  cur_be;
  logic [4:0]  cur_wait;
  logic [1:0]  cur_sdly, cur_rec;
  logic [3:0]  cur_gap;
  logic        cur_rdyen, cur_rdypol;
  logic [1:0]  str_left;
  logic        a30;

  // Phase and strobe qualifiers
  logic        strobe_phase, sel_phase, strobe_on, ready_act;

  ebbs_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .blk     (req_block),
    .status  (status),
    .sel_cr0 (sel_cr0),
    .sel_cr1 (sel_cr1),
    .sel_cr2 (sel_cr2)
  );

  // Pin inputs into the clock domain
  ebbs_sync #(.W(1), .RST(1'b1)) u_hold_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (hold_req_n),
    .q       (hold_sync_n)
  );

  ebbs_sync #(.W(1), .RST(1'b0)) u_rdy_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (ready_in),
    .q       (ready_sync)
  );

  ebbs_sync #(.W(32), .RST(32'h0000_0000)) u_data_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (data_in),
    .q       (data_sync)
  );

  // Request acceptance only when idle and not granted away
  assign req_ready = (state == EBBS_IDLE) && hold_sync_n;
  assign take      = req_valid && req_ready;

  // Configured ready level counts as active
  assign ready_act = (ready_sync == cur_rdypol);

  assign status = {28'h000_0000, state};

  // Latch the selected block's timing at acceptance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_blk    <= 3'h0;
      cur_write  <= 1'b0;
      cur_half   <= 1'b0;
      cur_sdram  <= 1'b0;
      cur_ip     <= 1'b0;
      cur_be     <= 4'h0;
      cur_wait   <= 5'h00;
      cur_sdly   <= 2'h0;
      cur_rec    <= 2'h0;
      cur_gap    <= 4'h0;
      cur_rdyen  <= 1'b0;
      cur_rdypol <= 1'b0;
    end else if (take) begin
      cur_blk    <= req_block;
      cur_write  <= req_write;
      cur_half   <= sel_cr0[EBBS_HALF_BIT];
      cur_sdram  <= req_sdram;
      cur_ip     <= req_block == 3'(EBBS_USER_IP_BLK);
      cur_be     <= req_be;
      cur_sdly   <= sel_cr0[EBBS_SDLY_LSB +: 2];
      cur_rdyen  <= sel_cr0[EBBS_RDYEN_BIT];
      cur_rdypol <= sel_cr0[EBBS_RDYPOL_BIT];
      cur_gap    <= sel_cr1[EBBS_GAP_LSB +: 4];
      // Page timing replaces the normal wait for bursts
      if (req_page)
        cur_wait <= req_write ? sel_cr1[EBBS_PWWAIT_LSB +: 5]
                              : sel_cr1[EBBS_PRWAIT_LSB +: 5];
      else
        cur_wait <= req_write ? sel_cr0[EBBS_WRITE_WAIT_COUNT_LSB +: 5]
                              : sel_cr0[EBBS_READ_WAIT_COUNT_LSB +: 5];
      cur_rec    <= req_write ? sel_cr1[EBBS_WREC_LSB +: 2]
                              : sel_cr1[EBBS_RREC_LSB +: 2];
    end
  end

  // Address held from acceptance until the next access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_addr <= 24'h00_0000;
      a30      <= 1'b1;
    end else if (take) begin
      ext_addr <= req_addr[25:2];
      a30      <= req_addr[1];
    end
  end

  // Write data held for the whole access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      data_out <= 32'h0000_0000;
    else if (take)
      data_out <= req_wdata;
  end

  // Phase sequencer
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      EBBS_IDLE: begin
        if (!hold_sync_n) begin
          next_state = EBBS_HOLD;
        end else if (take) begin
          if (sel_cr0[EBBS_SDLY_LSB +: 2] != 2'h0) begin
            next_state = EBBS_SELDLY;
            next_cnt   = 5'(sel_cr0[EBBS_SDLY_LSB +: 2] - 2'h1);
          end else begin
            next_state = EBBS_START;
          end
        end
      end
      EBBS_SELDLY: begin
        if (cnt == 5'h00)
          next_state = EBBS_START;
        else
          next_cnt = cnt - 5'h01;
      end
      EBBS_START: begin
        // One clock only, then wait, ready check or end
        if (cur_wait != 5'h00) begin
          next_state = EBBS_WAIT;
          next_cnt   = cur_wait - 5'h01;
        end else if (cur_rdyen && !ready_act) begin
          next_state = EBBS_RDYWAIT;
        end else begin
          next_state = EBBS_END;
        end
      end
      EBBS_WAIT: begin
        if (cnt != 5'h00)
          next_cnt = cnt - 5'h01;
        else if (cur_rdyen && !ready_act)
          next_state = EBBS_RDYWAIT;
        else
          next_state = EBBS_END;
      end
      EBBS_RDYWAIT: begin
        if (ready_act)
          next_state = EBBS_END;
      end
      EBBS_END: begin
        // One clock only, then recovery, gap or idle
        if (cur_rec != 2'h0) begin
          next_state = EBBS_RECOV;
          next_cnt   = 5'(cur_rec - 2'h1);
        end else if (cur_gap != 4'h0) begin
          next_state = EBBS_GAP;
          next_cnt   = 5'(cur_gap - 4'h1);
        end else begin
          next_state = EBBS_IDLE;
        end
      end
      EBBS_RECOV: begin
        if (cnt != 5'h00) begin
          next_cnt = cnt - 5'h01;
        end else if (cur_gap != 4'h0) begin
          next_state = EBBS_GAP;
          next_cnt   = 5'(cur_gap - 4'h1);
        end else begin
          next_state = EBBS_IDLE;
        end
      end
      EBBS_GAP: begin
        if (cnt == 5'h00)
          next_state = EBBS_IDLE;
        else
          next_cnt = cnt - 5'h01;
      end
      EBBS_HOLD: begin
        if (hold_sync_n)
          next_state = EBBS_IDLE;
      end
      default: begin
        next_state = EBBS_IDLE;
      end
    endcase
  end

  // State and phase counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= EBBS_IDLE;
      cnt   <= 5'h00;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Strobe delay counted from the start phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      str_left <= 2'h0;
    else if (take)
      str_left <= sel_cr2[EBBS_STRDLY_LSB +: 2];
    else if (strobe_phase && str_left != 2'h0)
      str_left <= str_left - 2'h1;
  end

  // Phase windows
  assign strobe_phase = state == EBBS_START || state == EBBS_WAIT ||
                        state == EBBS_RDYWAIT || state == EBBS_END;
  assign sel_phase    = strobe_phase || state == EBBS_RECOV;
  assign strobe_on    = strobe_phase && str_left == 2'h0 && !cur_sdram &&
                        !cur_ip;

  // Block selects: one low for the block, none for SDRAM
  always_comb begin
    block_select_n = 8'hFF;
    if (sel_phase && !cur_sdram)
      block_select_n[cur_blk] = 1'b0;
  end

  assign user_ip_bus_select = sel_phase && cur_ip && !cur_sdram;

  // Read strobe and direction
  assign read_strobe_n = !(strobe_on && !cur_write);
  assign read_write_n  = !(sel_phase && cur_write && !cur_sdram);

  // Byte lane write strobes
  always_comb begin
    byte_write_strobe_n = 4'hF;
    if (cur_half) begin
      byte_write_strobe_n[0] = !(strobe_on && cur_write && cur_be[0]);
      byte_write_strobe_n[1] = !(strobe_on && cur_write && cur_be[1]);
      byte_write_strobe_n[2] = a30;
    end else begin
      byte_write_strobe_n = ~({4{strobe_on && cur_write}} & cur_be);
    end
  end

  // Data drivers: lower half always, upper only full width
  always_comb begin
    data_oe = 2'b00;
    if (sel_phase && cur_write && !cur_sdram && !cur_ip) begin
      data_oe[0] = 1'b1;
      data_oe[1] = !cur_half;
    end
  end

  // Grant while the bus is handed over
  assign bus_grant_out_n = state != EBBS_HOLD;

  // Completion and read capture at the end phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid <= 1'b0;
      resp_rdata <= 32'h0000_0000;
    end else begin
      resp_valid <= state == EBBS_END;
      if (state == EBBS_END && !cur_write) begin
        if (cur_ip)
          resp_rdata <= ip_rdata;
        else if (cur_half)
          resp_rdata <= {16'h0000, data_sync[15:0]};
        else
          resp_rdata <= data_sync;
      end
    end
  end
endmodule // ebbs_top

// ===== ebbs_pkg.sv
package ebbs_pkg;

  // Geometry
  localparam int          EBBS_NBLK       = 8;
  localparam int          EBBS_USER_IP_BLK = 1;

  // Register offsets (block index in paddr[10:8])
  localparam logic [7:0]  EBBS_CR0_OFF    = 8'h00;
  localparam logic [7:0]  EBBS_CR1_OFF    = 8'h04;
  localparam logic [7:0]  EBBS_CR2_OFF    = 8'h08;
  localparam logic [11:0] EBBS_STAT_OFF   = 12'h800;

  // Control register 0 fields
  localparam int          EBBS_READ_WAIT_COUNT_LSB  = 0;
  localparam int          EBBS_WRITE_WAIT_COUNT_LSB  = 8;
  localparam int          EBBS_SDLY_LSB   = 16;
  localparam int          EBBS_RDYEN_BIT  = 18;
  localparam int          EBBS_RDYPOL_BIT = 19;
  localparam int          EBBS_HALF_BIT   = 20;

  // Control register 1 fields
  localparam int          EBBS_RREC_LSB   = 0;
  localparam int          EBBS_WREC_LSB   = 4;
  localparam int          EBBS_GAP_LSB    = 8;
  localparam int          EBBS_PRWAIT_LSB = 16;
  localparam int          EBBS_PWWAIT_LSB = 24;

  // Control register 2 fields
  localparam int          EBBS_STRDLY_LSB = 0;

  // Writable bits and reset values
  localparam logic [31:0] EBBS_CR0_MASK   = 32'h001F_1F1F;
  localparam logic [31:0] EBBS_CR1_MASK   = 32'h1F1F_0F33;
  localparam logic [31:0] EBBS_CR2_MASK   = 32'h0000_0003;
  localparam logic [31:0] EBBS_CR0_RST    = 32'h0003_1F1F;
  localparam logic [31:0] EBBS_CR1_RST    = 32'h1F1F_0F33;
  localparam logic [31:0] EBBS_CR2_RST    = 32'h0000_0000;

  // Access sequencer states
  typedef enum logic [3:0] {
    EBBS_IDLE,
    EBBS_SELDLY,
    EBBS_START,
    EBBS_WAIT,
    EBBS_RDYWAIT,
    EBBS_END,
    EBBS_RECOV,
    EBBS_GAP,
    EBBS_HOLD
  } ebbs_state_t;

endpackage

// ===== ebbs_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module ebbs_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage read only by second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= RST;
      q    <= RST;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // ebbs_sync

// ===== ebbs_regs.sv
`timescale 1ns/1ps
// APB register file: three control words per block plus status
module ebbs_regs
  import ebbs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  blk,
  input  wire logic [31:0] status,
  output logic      [31:0] sel_cr0,
  output logic      [31:0] sel_cr1,
  output logic      [31:0] sel_cr2
);
  logic [31:0] cr0 [EBBS_NBLK];
  logic [31:0] cr1 [EBBS_NBLK];
  logic [31:0] cr2 [EBBS_NBLK];
  logic [2:0]  ab;
  logic        hit0, hit1, hit2, hits;

  // Address decode
  assign ab   = paddr[10:8];
  assign hit0 = !paddr[11] && paddr[7:0] == EBBS_CR0_OFF;
  assign hit1 = !paddr[11] && paddr[7:0] == EBBS_CR1_OFF;
  assign hit2 = !paddr[11] && paddr[7:0] == EBBS_CR2_OFF;
  assign hits = paddr == EBBS_STAT_OFF;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(hit0 || hit1 || hit2 || hits ||
                   1'b0) ? 1'b1 : 1'b0;

  // Per-block configuration storage
  generate
    for (genvar i = 0; i < EBBS_NBLK; i++) begin : g_blk
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cr0[i] <= EBBS_CR0_RST;
          cr1[i] <= EBBS_CR1_RST;
          cr2[i] <= EBBS_CR2_RST;
        end else if (psel && penable && pwrite && ab == 3'(i)) begin
          if (hit0) cr0[i] <= pwdata & EBBS_CR0_MASK;
          if (hit1) cr1[i] <= pwdata & EBBS_CR1_MASK;
          if (hit2) cr2[i] <= pwdata & EBBS_CR2_MASK;
        end
      end
    end
  endgenerate

  // Read mux, zero for unmapped
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit0) prdata = cr0[ab];
    if (hit1) prdata = cr1[ab];
    if (hit2) prdata = cr2[ab];
    if (hits) prdata = status;
  end

  assign sel_cr0 = cr0[blk];
  assign sel_cr1 = cr1[blk];
  assign sel_cr2 = cr2[blk];
endmodule // ebbs_regs

// ===== ebbs_ext_mem.sv
`timescale 1ns/1ps
// External memory and ready source on the parallel bus
module ebbs_ext_mem (
  input  wire logic        pclk,
  input  wire logic [23:0] ext_addr,
  input  wire logic [31:0] data_out,
  input  wire logic [3:0]  byte_write_strobe_n,
  input  wire logic [7:0]  block_select_n,
  input  wire logic        half,
  input  wire logic        ready_pol,
  input  wire logic [4:0]  ready_dly,
  output logic      [31:0] data_in,
  output logic             ready_in
);
  logic [31:0] mem [256];
  logic [31:0] last;
  logic [4:0]  cnt;
  wire         sel = ~&block_select_n;
  initial begin
    foreach (mem[i]) mem[i] = '0;
    last = '0;
    cnt = '0;
  end
  // Byte lanes land while their strobe is low
  always @(posedge pclk) begin
    for (int j = 0; j < 4; j++)
      if (sel && !byte_write_strobe_n[j] && !(half && j > 1))
        mem[ext_addr[7:0]][8*j +: 8] <= data_out[8*j +: 8];
  end
  // Data toggles when unselected, ready held off for a set delay
  always @(posedge pclk) begin
    last <= data_in;
    cnt <= !sel ? 5'h00 : (cnt == 5'h1F ? cnt : cnt + 5'h01);
  end
  assign data_in  = sel ? mem[ext_addr[7:0]] : ~last;
  assign ready_in = (cnt >= ready_dly) ? ready_pol : ~ready_pol;
endmodule // ebbs_ext_mem

// ===== ebbs_checker.sv
`timescale 1ns/1ps
// Pin-level checks on the access sequencer
module ebbs_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       req_ready,
  input wire logic       resp_valid,
  input wire logic [1:0] data_oe,
  input wire logic       read_strobe_n,
  input wire logic [3:0] byte_write_strobe_n,
  input wire logic       read_write_n,
  input wire logic [7:0] block_select_n,
  input wire logic       hold_req_n,
  input wire logic       bus_grant_out_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Some block select is low
  sequence sel_on;
    !(&block_select_n);
  endsequence
  // Select spans start and end phases
  sequence sel_two;
    sel_on ##1 sel_on;
  endsequence
  // Select, strobe and grant relations
  chk_one_block: assert property ($onehot0(~block_select_n))
    else $error("more than one block select low");
  chk_sel_min: assert property ($fell(&block_select_n) |-> sel_two)
    else $error("select low for under two clocks");
  chk_read_dir: assert property (!read_strobe_n |->
    read_write_n && !(&block_select_n))
    else $error("read strobe without read direction");
  chk_write_lane: assert property (byte_write_strobe_n[1:0] != 2'b11 |->
    !read_write_n && data_oe[0])
    else $error("low lane strobe without driven data");
  chk_upper_lane: assert property (!byte_write_strobe_n[3] |->
    data_oe[1])
    else $error("lane three strobe without upper data");
  chk_ip_no_data: assert property (!block_select_n[1] |->
    data_oe == 2'b00)
    else $error("data driven for user bus block");
  chk_grant_quiet: assert property (!bus_grant_out_n |->
    &block_select_n && read_strobe_n && !req_ready && data_oe == 2'b00)
    else $error("bus active while granted away");
  chk_grant_drop: assert property ($rose(hold_req_n) |->
    ##[1:4] bus_grant_out_n)
    else $error("grant not released");
  chk_idle_quiet: assert property (req_ready |-> &block_select_n &&
    read_strobe_n && byte_write_strobe_n[1:0] == 2'b11 && data_oe == 2'b00)
    else $error("pins active while idle");
  chk_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("response longer than one clock");
endmodule // ebbs_checker
bind ebbs_top ebbs_checker chk_i (.pclk, .presetn, .req_ready, .resp_valid,
  .data_oe, .read_strobe_n, .byte_write_strobe_n, .read_write_n,
  .block_select_n, .hold_req_n, .bus_grant_out_n);

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ebbs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        req_valid, req_ready, req_write, req_page, req_sdram;
  logic        resp_valid, user_ip_bus_select, read_strobe_n, tk, hf;
  logic        read_write_n, hold_req_n, bus_grant_out_n, ready_in;
  logic        half, pol, perr, mon, rw_lo, ip_seen, rs_seen;
  logic [1:0]  data_oe, oe_seen, sd, rc, wc;
  logic [2:0]  req_block, b;
  logic [3:0]  req_be, byte_write_strobe_n, ws_seen, be, gp;
  logic [4:0]  dly, rwt, wwt;
  logic [7:0]  block_select_n, sel_seen;
  logic [11:0] paddr;
  logic [23:0] ext_addr;
  logic [25:0] req_addr, a;
  logic [31:0] pwdata, prdata, req_wdata, resp_rdata, ip_rdata, d, mask;
  logic [31:0] data_in, data_out, rd, sh [256];
  int          failures, checks_done, n, gap_n;
  ebbs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .req_valid, .req_ready, .req_block,
    .req_addr, .req_write, .req_be, .req_wdata, .req_page, .req_sdram,
    .resp_valid, .resp_rdata, .ip_rdata, .user_ip_bus_select, .ext_addr,
    .data_in, .data_out, .data_oe, .read_strobe_n, .byte_write_strobe_n,
    .read_write_n, .block_select_n, .hold_req_n, .bus_grant_out_n,
    .ready_in);
  ebbs_ext_mem ext (.pclk, .ext_addr, .data_out, .byte_write_strobe_n,
    .block_select_n, .half, .ready_pol(pol), .ready_dly(dly), .data_in,
    .ready_in);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Pin activity gathered during one access
  always @(negedge pclk) if (mon) begin
    sel_seen |= ~block_select_n;
    ws_seen |= ~byte_write_strobe_n;
    oe_seen |= data_oe;
    rw_lo |= ~read_write_n;
    ip_seen |= user_ip_bus_select;
    rs_seen |= ~read_strobe_n;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One APB transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // One bus access: n is clocks from take to response
  task automatic acc(input logic [2:0] bk, input logic w, input logic sdr);
    req_block <= bk;
    req_addr <= a;
    req_write <= w;
    req_be <= be;
    req_wdata <= d;
    req_sdram <= sdr;
    req_page <= 1'($urandom);
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      tk = req_ready;
      @(posedge pclk);
    end while (tk !== 1'b1 && ++n < 500);
    req_valid <= 1'b0;
    {sel_seen, ws_seen, oe_seen, rw_lo, ip_seen, rs_seen} = '0;
    mon = 1'b1;
    n = 1;
    forever begin
      @(negedge pclk);
      if (resp_valid === 1'b1 || n > 500) break;
      n++;
    end
    rd = resp_rdata;
    gap_n = 0;
    while (req_ready !== 1'b1 && gap_n < 99) begin
      @(negedge pclk);
      gap_n++;
    end
    mon = 1'b0;
    @(posedge pclk);
  endtask
  // Configure block b timing
  task automatic cfg(input logic rdy);
    apb(1'b1, {1'b0, b, EBBS_CR0_OFF},
        {11'h000, hf, pol, rdy, sd, 3'h0, wwt, 3'h0, rwt});
    apb(1'b1, {1'b0, b, EBBS_CR1_OFF}, {3'h0, wwt, 3'h0, rwt, 4'h0, gp,
        2'h0, wc, 2'h0, rc});
    half = hf;
  endtask
  initial begin
    {psel, penable, pwrite, req_valid, req_write, req_page, req_sdram} = '0;
    {presetn, half, pol, mon, dly, paddr, pwdata, req_block} = '0;
    {req_addr, req_be, req_wdata, ip_rdata, failures, checks_done} = '0;
    hold_req_n = 1'b1;
    foreach (sh[i]) sh[i] = '0;
    void'($urandom(32'h7fc3127c));
    repeat (6) @(posedge pclk);
    chk({block_select_n, byte_write_strobe_n, read_strobe_n}, 13'h1FFF);
    chk({data_oe, bus_grant_out_n}, 3'h1);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, 12'h300 + 12'(4 * k), '0);
      chk(rd, k == 0 ? EBBS_CR0_RST : k == 1 ? EBBS_CR1_RST : EBBS_CR2_RST);
    end
    d = $urandom;
    apb(1'b1, 12'h304, d);
    apb(1'b0, 12'h304, '0);
    chk(rd, d & EBBS_CR1_MASK);
    apb(1'b0, 12'h30C, '0);
    chk({31'h0000_0000, perr}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    apb(1'b0, EBBS_STAT_OFF, '0);
    chk(rd[3:0], 4'h0);
    $display("test registers done");
    // Block 1 at reset timing goes to the user bus
    ip_rdata <= $urandom;
    a = 26'($urandom);
    acc(3'h1, 1'b0, 1'b0);
    chk(n, 37);
    chk(rd, ip_rdata);
    chk({rs_seen, oe_seen, ip_seen, sel_seen},
        {1'b0, 2'b00, 1'b1, 8'h02});
    $display("test user bus done");
    for (int i = 0; i < 12; i++) begin
      b = 3'($urandom);
      if (b == 3'h1) b = 3'h0;
      {sd, rc, wc, gp, hf, wwt} = 16'($urandom);
      rwt = 5'($urandom_range(31, 2));
      cfg(1'b0);
      a = 26'($urandom);
      be = 4'($urandom);
      d = $urandom;
      mask = hf ? 32'h0000FFFF : 32'hFFFFFFFF;
      acc(b, 1'b1, 1'b0);
      chk(n, sd + wwt + 3);
      chk(gap_n, wc + gp);
      chk({rs_seen, sel_seen, oe_seen, rw_lo},
          {1'b0, 8'h01 << b, hf ? 2'b01 : 2'b11, 1'b1});
      chk(ws_seen, hf ? {1'b0, ~a[1], be[1:0]} : be);
      for (int j = 0; j < 4; j++)
        if (be[j] && !(hf && j > 1)) sh[a[9:2]][8*j +: 8] = d[8*j +: 8];
      acc(b, 1'b0, 1'b0);
      chk(n, sd + rwt + 3);
      chk(gap_n, rc + gp);
      chk({rs_seen, rw_lo, ws_seen}, {3'b100, hf & ~a[1], 2'b00});
      chk(rd & mask, sh[a[9:2]] & mask);
      chk(ext_addr, a[25:2]);
    end
    $display("test random accesses done");
    acc(3'h0, 1'b1, 1'b1);
    chk({sel_seen, oe_seen, rw_lo}, 11'h000);
    $display("test sdram area done");
    {b, sd, rwt, wwt, hf, gp, rc, wc} = {3'h2, 2'h0, 5'h02, 5'h02, 9'h000};
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      cfg(1'b1);
      dly = 5'h00;
      acc(b, 1'b0, 1'b0);
      chk(n, 5);
      dly = 5'h14;
      acc(b, 1'b0, 1'b0);
      chk(n >= 21 && n <= 28, 1'b1);
    end
    $display("test ready wait done");
    // Strobe delay: two clocks reach the end phase, three never do
    wwt = 5'h01;
    cfg(1'b0);
    be = 4'hF;
    for (int s = 2; s < 4; s++) begin
      apb(1'b1, {1'b0, b, EBBS_CR2_OFF}, 32'(s));
      acc(b, 1'b1, 1'b0);
      chk(ws_seen, s == 2 ? 4'hF : 4'h0);
    end
    $display("test strobe delay done");
    hold_req_n <= 1'b0;
    n = 0;
    do @(negedge pclk); while (bus_grant_out_n !== 1'b0 && ++n < 10);
    chk({bus_grant_out_n, req_ready, block_select_n}, 10'h0FF);
    @(posedge pclk);
    hold_req_n <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(bus_grant_out_n, 1'b1);
    $display("test bus hold done");
    tally_and_finish();
  end
  // Watchdog against a hung handshake
  initial begin
    #500000;
    failures++;
    tally_and_finish();
  end
endmodule // tb_top
